/* File: hdl/mac_status_regs.sv */
// Status, transmit queue pointer and interrupt registers of the Ethernet MAC.
`timescale 1ns/100ps
module mac_status_regs
    import mac_status_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        transmit_active,
    input  wire irq_events_t irq_events,
    input  wire rx_events_t  rx_events,
    input  wire tx_dma_t     tx_dma,
    input  wire rx_dma_t     rx_dma,
    output logic      [31:0] tx_desc_addr,
    output logic             rx_desc_refetch,
    output logic             rx_buffer_reclaim,
    output logic             irq
);

    // ==========================================================
    // Address decode
    logic wr_tx_ptr;
    logic wr_rx_status;
    logic wr_unmask;
    logic wr_mask;
    logic rd_irq_status;

    always_comb begin
        wr_tx_ptr     = reg_wr && reg_hit(reg_addr, TX_QUEUE_PTR_ADDR);
        wr_rx_status  = reg_wr && reg_hit(reg_addr, RX_STATUS_ADDR);
        wr_unmask     = reg_wr && reg_hit(reg_addr, IRQ_UNMASK_ADDR);
        wr_mask       = reg_wr && reg_hit(reg_addr, IRQ_MASK_ADDR);
        rd_irq_status = reg_rd && reg_hit(reg_addr, IRQ_STATUS_ADDR);
    end

    // ==========================================================
    // Transmit queue pointer
    // A write while a frame is going out would corrupt the descriptor walk, so it is dropped.
    logic        tx_ptr_load;
    logic [31:0] tx_current_ptr;
    logic [31:0] tx_frame_ptr;

    always_comb begin
        tx_ptr_load = wr_tx_ptr && !transmit_active;
    end

    tx_queue_pointer u_tx_queue_pointer (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .load        (tx_ptr_load),
        .load_value  (reg_wdata),
        .tx_dma      (tx_dma),
        .current_ptr (tx_current_ptr),
        .frame_ptr   (tx_frame_ptr)
    );

    // Bit 2 is stored as written; keeping it zero is up to software.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_desc_addr <= TX_PTR_RESET;
        end else begin
            tx_desc_addr <= tx_current_ptr;
        end
    end

    // ==========================================================
    // Receive status flags
    logic [2:0] rx_status_r;
    logic [2:0] rx_status_nxt;
    logic [2:0] rx_status_set;
    logic [2:0] rx_status_clr;

    always_comb begin
        rx_status_set                     = 3'h0;
        rx_status_set[RX_BUF_UNAVAIL_BIT] = rx_events.rx_buffer_unavailable;
        rx_status_set[FRAME_RECEIVED_BIT] = rx_events.frame_received;
        rx_status_set[RX_OVERRUN_BIT]     = rx_events.rx_overrun;
        rx_status_clr = wr_rx_status ? reg_wdata[2:0] : 3'h0;
        // A new event in the clearing cycle stays set.
        rx_status_nxt = (rx_status_r & ~rx_status_clr) | rx_status_set;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_status_r <= RX_STATUS_RESET;
        end else begin
            rx_status_r <= rx_status_nxt;
        end
    end

    // ==========================================================
    // Receive descriptor re-fetch after a failed buffer grab
    rx_fetch_state_t rx_fetch_r;
    rx_fetch_state_t rx_fetch_nxt;

    always_comb begin
        rx_fetch_nxt = rx_fetch_r;
        unique case (rx_fetch_r)
            RX_FETCH_NORMAL: begin
                if (rx_events.rx_buffer_unavailable) begin
                    rx_fetch_nxt = RX_FETCH_RETRY;
                end
            end
            RX_FETCH_RETRY: begin
                if (rx_dma.buffer_acquired && !rx_events.rx_buffer_unavailable) begin
                    rx_fetch_nxt = RX_FETCH_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_fetch_r <= RX_FETCH_NORMAL;
        end else begin
            rx_fetch_r <= rx_fetch_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_desc_refetch <= 1'b0;
        end else begin
            rx_desc_refetch <= (rx_fetch_r == RX_FETCH_RETRY) && rx_dma.frame_start;
        end
    end

    // The buffer of a frame that could not be stored goes back to the free pool.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_buffer_reclaim <= 1'b0;
        end else begin
            rx_buffer_reclaim <= rx_events.rx_overrun;
        end
    end

    // ==========================================================
    // Interrupt status
    logic [31:0] irq_status_r;
    logic [31:0] irq_status_nxt;
    logic [31:0] irq_status_set;
    irq_events_t irq_src;

    always_comb begin
        irq_src                           = irq_events;
        irq_src.management_done           = irq_events.management_done;
        irq_src.rx_done                   = irq_events.rx_done;
        irq_src.rx_descriptor_unavailable = irq_events.rx_descriptor_unavailable;
        irq_src.tx_descriptor_unavailable = irq_events.tx_descriptor_unavailable;
        irq_src.tx_underrun               = irq_events.tx_underrun | tx_ptr_load;
        irq_src.tx_midframe_exhaust       = irq_events.tx_midframe_exhaust;
        irq_src.tx_done                   = irq_events.tx_done;
        irq_src.rx_overflow               = irq_events.rx_overflow
                                          | rx_events.rx_overrun;
        irq_src.bus_error                 = irq_events.bus_error;
        irq_src.pause_frame_seen          = irq_events.pause_frame_seen;
        irq_src.pause_expired             = irq_events.pause_expired;
        irq_status_set = irq_vector(irq_src) & IRQ_VALID_MASK;
        // The read returns the old value; an event in the same cycle survives the clear.
        irq_status_nxt = (rd_irq_status ? IRQ_STATUS_RESET : irq_status_r)
                       | irq_status_set;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status_r <= IRQ_STATUS_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    // ==========================================================
    // Interrupt mask, one bit per source, one meaning masked
    logic [31:0] irq_mask_r;
    logic [31:0] irq_mask_nxt;
    logic [31:0] unmask_bits;
    logic [31:0] mask_bits;

    always_comb begin
        unmask_bits  = wr_unmask ? (reg_wdata & IRQ_VALID_MASK) : 32'h00000000;
        mask_bits    = wr_mask ? (reg_wdata & IRQ_VALID_MASK) : 32'h00000000;
        irq_mask_nxt = (irq_mask_r & ~unmask_bits) | mask_bits;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask_r <= IRQ_MASK_RESET;
        end else begin
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ==========================================================
    // Interrupt request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & ~irq_mask_r & IRQ_VALID_MASK);
        end
    end

    // ==========================================================
    // Read data
    logic [31:0] read_mux;

    always_comb begin
        read_mux = READ_DATA_RESET;
        if (reg_hit(reg_addr, TX_QUEUE_PTR_ADDR)) begin
            read_mux = tx_frame_ptr;
        end else if (reg_hit(reg_addr, RX_STATUS_ADDR)) begin
            read_mux = {29'h0, rx_status_r};
        end else if (reg_hit(reg_addr, IRQ_STATUS_ADDR)) begin
            read_mux = irq_status_r;
        end else if (reg_hit(reg_addr, IRQ_MASK_READBACK_ADDR)) begin
            read_mux = irq_mask_r;
        end else if (reg_hit(reg_addr, TRANSMIT_STATUS_ADDR)) begin
            read_mux[TRANSMIT_ACTIVE_BIT] = transmit_active;
        end
    end

    // Data stand for exactly one cycle after the read strobe, zero otherwise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_DATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= READ_DATA_RESET;
        end
    end

endmodule : mac_status_regs

/* File: hdl/tx_queue_pointer.sv */
// Transmit descriptor queue pointer with buffer stepping and frame-start capture.
`timescale 1ns/100ps
module tx_queue_pointer
    import mac_status_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    input  wire tx_dma_t     tx_dma,
    output logic      [31:0] current_ptr,
    output logic      [31:0] frame_ptr
);

    logic [31:0]           base_r;
    logic [TX_INDEX_W-1:0] index_r;

    // ==========================================================
    // Walking pointer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            base_r      <= TX_PTR_RESET;
            index_r     <= '0;
            current_ptr <= TX_PTR_RESET;
        end else if (load) begin
            base_r      <= load_value & TX_PTR_VALID_MASK;
            index_r     <= '0;
            current_ptr <= load_value & TX_PTR_VALID_MASK;
        end else if (tx_dma.buffer_consumed) begin
            if (tx_dma.wrap_seen || index_r == TX_INDEX_LAST) begin
                index_r     <= '0;
                current_ptr <= base_r;
            end else begin
                index_r     <= index_r + 10'h001;
                current_ptr <= (current_ptr + TX_DESC_STRIDE) & TX_PTR_VALID_MASK;
            end
        end
    end

    // ==========================================================
    // First buffer of the frame in flight
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_ptr <= TX_PTR_RESET;
        end else if (load) begin
            frame_ptr <= load_value & TX_PTR_VALID_MASK;
        end else if (tx_dma.frame_start) begin
            frame_ptr <= current_ptr;
        end
    end

endmodule : tx_queue_pointer

/* File: include/mac_status_pkg.sv */
// Constants, types and helpers shared by the MAC status and interrupt block.
// Behaviour
// - Transmit pointer steps per consumed buffer; returns to start after 1024 or wrap.
// - Transmit pointer writes are accepted only while transmit is not active.
// - Write sets descriptor list start; read gives first buffer of current frame.
// - Receive status flags clear only by writing one; writes never set them.
// - Buffer-unavailable flag sets on every failed receive buffer attempt.
// - After a failed attempt, receive pointer is re-fetched at each frame start until a buffer is acquired.
// - Frame-received flag sets once frames are fully stored in memory.
// - Overrun flag sets when a frame cannot be stored; the buffer is reclaimed.
// - Interrupt status clears on read; fixed bit layout 0..7 and 10..13.
// - Management-done flag sets when the PHY maintenance operation finishes.
// - Receive-complete flag sets when a frame is completely stored.
// - Used-bit flags set when a fetched descriptor is not available.
// - Underrun flag sets on late data, bus error, mid-frame used bit, pointer write accepted while transmit is not active.
// - Transmit error flag sets when buffers run out mid-frame.
// - Transmit-complete flag sets when a frame has been sent.
// - Receive overrun interrupt flag follows the receive overrun condition.
// - Bus-error flag sets on any system bus error response to the DMA.
// - Pause-received flag sets on a valid pause frame.
// - Pause-zero flag sets when the pause time counter reaches zero.
// - Writing one to the unmask register unmasks that source.
// - Writing one to the mask register masks that source.
// - Mask readback register reports which sources are masked.
// - Transmit-active flag reads high while a transmission is in progress.
package mac_status_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [31:0] TRANSMIT_STATUS_ADDR    = 32'hF802C014;
    localparam logic [31:0] TX_QUEUE_PTR_ADDR       = 32'hF802C01C;
    localparam logic [31:0] RX_STATUS_ADDR          = 32'hF802C020;
    localparam logic [31:0] IRQ_STATUS_ADDR         = 32'hF802C024;
    localparam logic [31:0] IRQ_UNMASK_ADDR         = 32'hF802C028;
    localparam logic [31:0] IRQ_MASK_ADDR           = 32'hF802C02C;
    localparam logic [31:0] IRQ_MASK_READBACK_ADDR  = 32'hF802C030;

    // ==========================================================
    // Field positions
    localparam int unsigned TRANSMIT_ACTIVE_BIT     = 3;
    localparam int unsigned RX_BUF_UNAVAIL_BIT      = 0;
    localparam int unsigned FRAME_RECEIVED_BIT      = 1;
    localparam int unsigned RX_OVERRUN_BIT          = 2;
    localparam int unsigned IRQ_MGMT_DONE_BIT       = 0;
    localparam int unsigned IRQ_RX_DONE_BIT         = 1;
    localparam int unsigned IRQ_RX_DESC_BIT         = 2;
    localparam int unsigned IRQ_TX_DESC_BIT         = 3;
    localparam int unsigned IRQ_TX_UNDERRUN_BIT     = 4;
    localparam int unsigned IRQ_RETRY_LIMIT_BIT     = 5;
    localparam int unsigned IRQ_TX_EXHAUST_BIT      = 6;
    localparam int unsigned IRQ_TX_DONE_BIT         = 7;
    localparam int unsigned IRQ_RX_OVERFLOW_BIT     = 10;
    localparam int unsigned IRQ_BUS_ERROR_BIT       = 11;
    localparam int unsigned IRQ_PAUSE_SEEN_BIT      = 12;
    localparam int unsigned IRQ_PAUSE_EXPIRED_BIT   = 13;
    localparam logic [31:0] IRQ_VALID_MASK          = 32'h00003CFF;
    localparam logic [31:0] TX_PTR_VALID_MASK       = 32'hFFFFFFFC;

    // ==========================================================
    // Reset values and counts
    localparam logic [31:0] TX_PTR_RESET            = 32'h00000000;
    localparam logic [2:0]  RX_STATUS_RESET         = 3'h0;
    localparam logic [31:0] IRQ_STATUS_RESET        = 32'h00000000;
    localparam logic [31:0] IRQ_MASK_RESET          = IRQ_VALID_MASK;
    localparam logic [31:0] READ_DATA_RESET         = 32'h00000000;
    localparam int unsigned TX_WRAP_COUNT           = 1024;
    localparam int unsigned TX_INDEX_W              = 10;
    localparam logic [9:0]  TX_INDEX_LAST           = 10'(TX_WRAP_COUNT - 1);
    localparam logic [31:0] TX_DESC_STRIDE          = 32'h00000008;

    // ==========================================================
    // Event carriers
    typedef struct packed {
        logic management_done;
        logic rx_done;
        logic rx_descriptor_unavailable;
        logic tx_descriptor_unavailable;
        logic tx_underrun;
        logic retry_limit;
        logic tx_midframe_exhaust;
        logic tx_done;
        logic rx_overflow;
        logic bus_error;
        logic pause_frame_seen;
        logic pause_expired;
    } irq_events_t;

    typedef struct packed {
        logic rx_buffer_unavailable;
        logic frame_received;
        logic rx_overrun;
    } rx_events_t;

    typedef struct packed {
        logic buffer_consumed;
        logic wrap_seen;
        logic frame_start;
    } tx_dma_t;

    typedef struct packed {
        logic frame_start;
        logic buffer_acquired;
    } rx_dma_t;

    typedef enum logic {
        RX_FETCH_NORMAL = 1'b0,
        RX_FETCH_RETRY  = 1'b1
    } rx_fetch_state_t;

    // Places the event pulses in the interrupt status layout.
    function automatic logic [31:0] irq_vector(input irq_events_t e);
        logic [31:0] v;
        v = 32'h00000000;
        v[IRQ_MGMT_DONE_BIT]     = e.management_done;
        v[IRQ_RX_DONE_BIT]       = e.rx_done;
        v[IRQ_RX_DESC_BIT]       = e.rx_descriptor_unavailable;
        v[IRQ_TX_DESC_BIT]       = e.tx_descriptor_unavailable;
        v[IRQ_TX_UNDERRUN_BIT]   = e.tx_underrun;
        v[IRQ_RETRY_LIMIT_BIT]   = e.retry_limit;
        v[IRQ_TX_EXHAUST_BIT]    = e.tx_midframe_exhaust;
        v[IRQ_TX_DONE_BIT]       = e.tx_done;
        v[IRQ_RX_OVERFLOW_BIT]   = e.rx_overflow;
        v[IRQ_BUS_ERROR_BIT]     = e.bus_error;
        v[IRQ_PAUSE_SEEN_BIT]    = e.pause_frame_seen;
        v[IRQ_PAUSE_EXPIRED_BIT] = e.pause_expired;
        return v;
    endfunction : irq_vector

    // True when a bus address selects the given register.
    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        return addr == reg_addr;
    endfunction : reg_hit

endpackage : mac_status_pkg

/* File: verification/mac_far_side_model.sv */
// Behavioural DMA and PHY side that turns bench requests into event pulses.
`timescale 1ns/100ps
module mac_far_side_model
    import mac_status_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [19:0] ev_req,
    input  wire logic        go,
    output irq_events_t      irq_events,
    output rx_events_t       rx_events,
    output tx_dma_t          tx_dma,
    output rx_dma_t          rx_dma,
    output logic             transmit_active
);
    // ==========================================================
    // Event pulses
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {irq_events, rx_events, tx_dma, rx_dma} <= '0;
            transmit_active <= 1'b0;
        end else begin
            // A wrap mark only travels with a consumed buffer.
            {irq_events, rx_events, tx_dma, rx_dma} <= {ev_req[19:4], ev_req[3] & ev_req[4],
                                                        ev_req[2:0]};
            transmit_active <= go;
        end
    end
endmodule : mac_far_side_model

/* File: verification/mac_status_checker.sv */
// Port-level checks for the MAC status and interrupt registers.
`timescale 1ns/100ps
module mac_status_checker
    import mac_status_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        transmit_active,
    input wire irq_events_t irq_events,
    input wire rx_events_t  rx_events,
    input wire tx_dma_t     tx_dma,
    input wire rx_dma_t     rx_dma,
    input wire logic [31:0] tx_desc_addr,
    input wire logic        rx_desc_refetch,
    input wire logic        rx_buffer_reclaim,
    input wire logic        irq
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_idle;
        !reg_wr && !reg_rd;
    endsequence
    sequence s_unmask_done;
        reg_wr && reg_addr == IRQ_UNMASK_ADDR && reg_wdata[IRQ_TX_DONE_BIT];
    endsequence
    sequence s_isr_read;
        reg_rd && reg_addr == IRQ_STATUS_ADDR;
    endsequence
    property p_isr_clear;
        (reg_rd && reg_addr == IRQ_STATUS_ADDR && irq_events == '0 && !rx_events.rx_overrun)
        ##1 (irq_events == '0 && !rx_events.rx_overrun && !reg_wr) ##1 s_isr_read
        |=> reg_rdata == 32'h00000000;
    endproperty
    property p_irq_raise;
        s_unmask_done ##1 (irq_events.tx_done && !reg_wr && !reg_rd) ##1 s_idle |=> irq;
    endproperty
    property p_mask_readback;
        (reg_wr && reg_addr == IRQ_MASK_ADDR && reg_wdata == IRQ_VALID_MASK) ##1 s_idle
        ##1 (reg_rd && reg_addr == IRQ_MASK_READBACK_ADDR) |=> reg_rdata == IRQ_VALID_MASK;
    endproperty
    property p_wo_read;
        reg_rd && (reg_addr == IRQ_UNMASK_ADDR || reg_addr == IRQ_MASK_ADDR)
        |=> reg_rdata == 32'h00000000;
    endproperty
    property p_tsr_read;
        reg_rd && reg_addr == TRANSMIT_STATUS_ADDR
        |=> reg_rdata == {28'h0000000, $past(transmit_active), 3'h0};
    endproperty
    property p_ptr_load;
        (reg_wr && reg_addr == TX_QUEUE_PTR_ADDR && !transmit_active && tx_dma == '0)
        ##1 (tx_dma == '0) |=> tx_desc_addr == ($past(reg_wdata, 2) & TX_PTR_VALID_MASK);
    endproperty
    property p_ptr_lock;
        (reg_wr && reg_addr == TX_QUEUE_PTR_ADDR && transmit_active && tx_dma == '0)
        ##1 (tx_dma == '0) |=> $stable(tx_desc_addr);
    endproperty
    property p_refetch;
        rx_events.rx_buffer_unavailable ##1 (rx_dma.frame_start && !rx_dma.buffer_acquired)
        |=> rx_desc_refetch;
    endproperty
    property p_reclaim;
        rx_buffer_reclaim == $past(rx_events.rx_overrun);
    endproperty
    a_isr_clear: assert property (p_isr_clear)
        else $error("status not cleared by read");
    a_irq_raise: assert property (p_irq_raise)
        else $error("irq did not rise");
    a_mask_readback: assert property (p_mask_readback)
        else $error("mask readback wrong");
    a_wo_read: assert property (p_wo_read)
        else $error("write-only register read nonzero");
    a_tsr_read: assert property (p_tsr_read)
        else $error("transmit active readback wrong");
    a_ptr_load: assert property (p_ptr_load)
        else $error("tx pointer load wrong");
    a_ptr_lock: assert property (p_ptr_lock)
        else $error("tx pointer written while active");
    a_refetch: assert property (p_refetch)
        else $error("no receive refetch");
    a_reclaim: assert property (p_reclaim)
        else $error("reclaim pulse wrong");
endmodule : mac_status_checker

/* File: verification/mac_status_regs_bench.sv */
// Self-checking bench for the MAC status and interrupt registers.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module mac_status_regs_bench
    import mac_status_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] reg_addr = 32'h00000000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [19:0] ev_req = 20'h00000;
    logic        go = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] tx_desc_addr;
    logic        rx_desc_refetch;
    logic        rx_buffer_reclaim;
    logic        irq;
    logic        transmit_active;
    irq_events_t irq_events;
    rx_events_t  rx_events;
    tx_dma_t     tx_dma;
    rx_dma_t     rx_dma;
    int          bad_count = 0;
    int          checked = 0;
    int          pos [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13};

    // ==========================================================
    // Clock, design and far side
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    mac_status_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transmit_active(transmit_active), .irq_events(irq_events), .rx_events(rx_events),
        .tx_dma(tx_dma), .rx_dma(rx_dma), .tx_desc_addr(tx_desc_addr),
        .rx_desc_refetch(rx_desc_refetch), .rx_buffer_reclaim(rx_buffer_reclaim), .irq(irq));
    mac_far_side_model i_far (.sys_clk(sys_clk), .rst(rst), .ev_req(ev_req), .go(go),
        .irq_events(irq_events), .rx_events(rx_events), .tx_dma(tx_dma), .rx_dma(rx_dma),
        .transmit_active(transmit_active));

    // ==========================================================
    // Access tasks
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK($sformatf("reg %h", a), e, reg_rdata)
        @(posedge sys_clk);
    endtask : rd
    task automatic ev(input logic [19:0] a, input logic [19:0] b);
        ev_req <= a;
        @(posedge sys_clk);
        ev_req <= b;
        @(posedge sys_clk);
        ev_req <= 20'h00000;
        @(posedge sys_clk);
    endtask : ev
    task automatic chk_irq(input logic e);
        #1;
        `CHK("irq", e, irq)
        @(posedge sys_clk);
    endtask : chk_irq
    task automatic print_verdict();
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Tests
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(IRQ_MASK_READBACK_ADDR, IRQ_VALID_MASK);
        rd(TRANSMIT_STATUS_ADDR, 32'h00000000);
        rd(32'hF802C040, 32'h00000000);
        rd(IRQ_UNMASK_ADDR, 32'h00000000);
        for (int i = 0; i < 12; i++) begin
            ev(20'h00001 << (19 - i), 20'h00000);
            chk_irq(1'b0);
            rd(IRQ_STATUS_ADDR, 32'h00000001 << pos[i]);
            rd(IRQ_STATUS_ADDR, 32'h00000000);
        end
        fork
            wr(IRQ_UNMASK_ADDR, 32'h00000080);
            ev(20'h01000, 20'h00000);
        join
        chk_irq(1'b1);
        rd(IRQ_MASK_READBACK_ADDR, 32'h00003C7F);
        rd(IRQ_STATUS_ADDR, 32'h00000080);
        chk_irq(1'b0);
        wr(IRQ_UNMASK_ADDR, 32'h00000000);
        rd(IRQ_MASK_READBACK_ADDR, 32'h00003C7F);
        wr(IRQ_MASK_ADDR, 32'h00003CFF);
        rd(IRQ_MASK_READBACK_ADDR, 32'h00003CFF);
        ev(20'h00080, 20'h00002);
        rd(RX_STATUS_ADDR, 32'h00000001);
        wr(RX_STATUS_ADDR, 32'h00000001);
        rd(RX_STATUS_ADDR, 32'h00000000);
        ev(20'h00080, 20'h00002);
        rd(RX_STATUS_ADDR, 32'h00000001);
        ev(20'h00040, 20'h00021);
        rd(RX_STATUS_ADDR, 32'h00000007);
        wr(RX_STATUS_ADDR, 32'h00000000);
        rd(RX_STATUS_ADDR, 32'h00000007);
        wr(RX_STATUS_ADDR, 32'h00000002);
        rd(RX_STATUS_ADDR, 32'h00000005);
        wr(RX_STATUS_ADDR, 32'h00000005);
        rd(RX_STATUS_ADDR, 32'h00000000);
        rd(IRQ_STATUS_ADDR, 32'h00000400);
        wr(TX_QUEUE_PTR_ADDR, 32'h10000103);
        rd(TX_QUEUE_PTR_ADDR, 32'h10000100);
        rd(IRQ_STATUS_ADDR, 32'h00000010);
        go <= 1'b1;
        @(posedge sys_clk);
        wr(TX_QUEUE_PTR_ADDR, 32'h20000000);
        rd(TX_QUEUE_PTR_ADDR, 32'h10000100);
        rd(IRQ_STATUS_ADDR, 32'h00000000);
        rd(TRANSMIT_STATUS_ADDR, 32'h00000008);
        ev(20'h00010, 20'h00010);
        ev(20'h00010, 20'h00004);
        rd(TX_QUEUE_PTR_ADDR, 32'h10000118);
        ev(20'h00018, 20'h00004);
        rd(TX_QUEUE_PTR_ADDR, 32'h10000100);
        ev_req <= 20'h00010;
        repeat (1023) @(posedge sys_clk);
        ev(20'h00004, 20'h00000);
        rd(TX_QUEUE_PTR_ADDR, 32'h100020F8);
        ev(20'h00010, 20'h00004);
        rd(TX_QUEUE_PTR_ADDR, 32'h10000100);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
endmodule : mac_status_regs_bench

bind mac_status_regs mac_status_checker i_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .transmit_active(transmit_active), .irq_events(irq_events),
    .rx_events(rx_events), .tx_dma(tx_dma), .rx_dma(rx_dma), .tx_desc_addr(tx_desc_addr),
    .rx_desc_refetch(rx_desc_refetch), .rx_buffer_reclaim(rx_buffer_reclaim), .irq(irq));
